// ### rtl/flash_susp_pkg.sv
// package: suspend/resume parameter word, timing counts and carrier types
package flash_susp_pkg;
    // parameter word, returned low byte first at byte offsets 2C..2F
    localparam logic [31:0] SUSP_WORD = 32'h451893EC;
    localparam logic [7:0] WORD_BASE = 8'h2C;
    localparam logic [7:0] WORD_LAST = 8'h2F;
    localparam int SUPPORT_BIT = 31;
    localparam int RFU_BIT = 8;
    localparam int ER_UNIT_HI = 30;
    localparam int ER_UNIT_LO = 29;
    localparam int ER_CNT_HI = 28;
    localparam int ER_CNT_LO = 24;
    localparam int PG_UNIT_HI = 19;
    localparam int PG_UNIT_LO = 18;
    localparam int PG_CNT_HI = 17;
    localparam int PG_CNT_LO = 13;
    // latency units in ns for unit codes 00b..11b
    localparam logic [31:0] UNIT_0_NS = 32'd128;
    localparam logic [31:0] UNIT_1_NS = 32'd1000;
    localparam logic [31:0] UNIT_2_NS = 32'd8000;
    localparam logic [31:0] UNIT_3_NS = 32'd64000;
    // timing
    localparam int CLK_NS = 50;
    localparam int SUSP_MAX_NS = 48000;
    localparam int SUSP_MAX_CYC = SUSP_MAX_NS / CLK_NS;
    localparam int RES_GAP_NS = 128000;
    localparam int RES_GAP_CYC = (RES_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0] SUSP_ENTRY_CYC = 6'd40;
    localparam logic [11:0] GAP_CYC = 12'(RES_GAP_CYC);
    localparam logic [11:0] ERASE_CYC = 12'd4000;
    localparam logic [11:0] PROG_CYC = 12'd1000;
    localparam int SECT_W = 12;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RUN   = 3'b001,
        ST_DRAIN = 3'b011,
        ST_SUSP  = 3'b010,
        ST_NEST  = 3'b110
    } seq_state_t;

    typedef struct packed {
        logic start_erase;
        logic start_prog;
        logic suspend;
        logic resume;
        logic [SECT_W-1:0] sector;
    } op_req_t;

    typedef struct packed {
        logic busy;
        logic suspended;
        logic susp_is_erase;
        logic done;
        logic refused;
        logic early_suspend;
    } op_stat_t;

    // decoded max latency in ns: (count + 1) * unit
    function automatic logic [31:0] lat_ns(input logic [1:0] unit, input logic [4:0] cnt);
        logic [31:0] u;
        u = UNIT_0_NS;
        case (unit)
            2'h1: u = UNIT_1_NS;
            2'h2: u = UNIT_2_NS;
            2'h3: u = UNIT_3_NS;
            default: u = UNIT_0_NS;
        endcase
        return 32'(({27'h0, cnt} + 32'h1) * u);
    endfunction : lat_ns
endpackage : flash_susp_pkg

// ### rtl/flash_susp_seq.sv
// suspend/resume sequencer and its discoverable parameter word
// Function
// - offsets 2C..2F return EC 93 18 45
// - word top bit reads zero: supported
// - erase suspends within 48 us
// - unit codes 128ns/1us/8us/64us, (count+1)*unit
// - program suspends within 48 us, unless nested in an erase suspend
// - word bit 8 reads one
module flash_susp_seq
    import flash_susp_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // parameter read
    input wire logic i_param_rd,
    input wire logic [7:0] i_param_addr,
    output logic o_param_valid,
    output logic o_param_hit,
    output logic [7:0] o_param_data,
    // embedded operations
    input wire op_req_t i_req,
    output op_stat_t o_stat
);
    typedef struct packed {
        seq_state_t st;
        logic erase;
        logic [SECT_W-1:0] sector;
        logic [11:0] cnt;
        logic [11:0] nest_cnt;
        logic [5:0] lat;
        logic [11:0] gap;
        logic p_valid;
        logic p_hit;
        logic [7:0] p_data;
        op_stat_t stat;
    } state_t;

    state_t q;
    state_t d;
    logic [7:0] rel;

    assign rel = i_param_addr - WORD_BASE;

    always_comb begin
        d = q;
        d.stat.done = 1'b0;
        d.stat.refused = 1'b0;
        d.stat.early_suspend = 1'b0;
        d.p_valid = i_param_rd;
        if (i_param_rd) begin
            if (i_param_addr >= WORD_BASE && i_param_addr <= WORD_LAST) begin
                d.p_hit = 1'b1;
                d.p_data = SUSP_WORD[{rel[1:0], 3'b000} +: 8];
            end else begin
                d.p_hit = 1'b0;
                d.p_data = 8'h00;
            end
        end
        if (q.gap != 12'h000) begin
            d.gap = q.gap - 12'h001;
        end
        unique case (q.st)
            ST_IDLE: begin
                if (i_req.start_erase || i_req.start_prog) begin
                    d.st = ST_RUN;
                    d.erase = i_req.start_erase;
                    d.cnt = i_req.start_erase ? ERASE_CYC : PROG_CYC;
                    d.sector = i_req.sector;
                end
            end
            ST_RUN: begin
                if (i_req.start_erase || i_req.start_prog) begin
                    d.stat.refused = 1'b1;
                end
                if (i_req.suspend) begin
                    d.st = ST_DRAIN;
                    d.lat = SUSP_ENTRY_CYC - 6'h01;
                    d.stat.early_suspend = q.gap != 12'h000;
                end else if (q.cnt == 12'h001) begin
                    d.st = ST_IDLE;
                    d.stat.done = 1'b1;
                end else begin
                    d.cnt = q.cnt - 12'h001;
                end
            end
            ST_DRAIN: begin
                if (q.lat == 6'h00) begin
                    d.st = ST_SUSP;
                end else begin
                    d.lat = q.lat - 6'h01;
                end
            end
            ST_SUSP: begin
                // progress count held here
                if (i_req.resume) begin
                    d.st = ST_RUN;
                    d.gap = GAP_CYC;
                end else if (i_req.start_erase) begin
                    d.stat.refused = 1'b1;
                end else if (i_req.start_prog) begin
                    if (q.erase && i_req.sector != q.sector) begin
                        d.st = ST_NEST;
                        d.nest_cnt = PROG_CYC;
                    end else begin
                        d.stat.refused = 1'b1;
                    end
                end
            end
            ST_NEST: begin
                if (i_req.start_erase || i_req.start_prog || i_req.resume) begin
                    d.stat.refused = 1'b1;
                end
                if (q.nest_cnt == 12'h001) begin
                    d.st = ST_SUSP;
                    d.stat.done = 1'b1;
                end else begin
                    d.nest_cnt = q.nest_cnt - 12'h001;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        d.stat.busy = d.st != ST_IDLE && d.st != ST_SUSP;
        d.stat.suspended = d.st == ST_SUSP || d.st == ST_NEST;
        d.stat.susp_is_erase = d.stat.suspended && d.erase;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_param_valid = q.p_valid;
    assign o_param_hit = q.p_hit;
    assign o_param_data = q.p_data;
    assign o_stat = q.stat;

    localparam int c_lat_hi = SUSP_MAX_CYC;

    sequence s_susp_req(logic is_erase);
        q.st == ST_RUN && q.erase == is_erase && i_req.suspend;
    endsequence

    sequence s_held;
        q.st == ST_SUSP && !i_req.resume && !i_req.start_prog;
    endsequence

    property p_word_bytes;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_param_rd && i_param_addr == WORD_BASE ##1 i_param_rd && i_param_addr == 8'h2D
        |-> o_param_hit && o_param_data == 8'hEC ##1 o_param_hit && o_param_data == 8'h93;
    endproperty
    a_word_bytes: assert property (p_word_bytes) else $error("parameter bytes wrong");

    property p_first_byte;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_param_rd && i_param_addr == WORD_BASE |=> o_param_valid && o_param_data == 8'hEC;
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("byte 2C not EC");

    property p_support_bit;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_param_rd && i_param_addr == WORD_LAST |=> o_param_data == 8'h45 && !o_param_data[7];
    endproperty
    a_support_bit: assert property (p_support_bit) else $error("support bit not zero");

    property p_rfu_bit;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_param_rd && i_param_addr == 8'h2D |=> o_param_hit && o_param_data[0];
    endproperty
    a_rfu_bit: assert property (p_rfu_bit) else $error("reserved bit 8 not one");

    property p_units;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_param_rd && i_param_addr == WORD_LAST
        |=> lat_ns(o_param_data[6:5], o_param_data[4:0]) == 32'(SUSP_MAX_NS);
    endproperty
    a_units: assert property (p_units) else $error("latency field decode wrong");

    property p_erase_lat;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        s_susp_req(1'b1) |=> q.st == ST_DRAIN ##[1:c_lat_hi]
            o_stat.suspended && o_stat.susp_is_erase;
    endproperty
    a_erase_lat: assert property (p_erase_lat) else $error("erase suspend too slow");

    property p_prog_lat;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        s_susp_req(1'b0) |=> q.st == ST_DRAIN ##[1:c_lat_hi]
            o_stat.suspended && !o_stat.susp_is_erase;
    endproperty
    a_prog_lat: assert property (p_prog_lat) else $error("program suspend too slow");

    property p_frozen;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        s_held |=> $stable(q.cnt) && $stable(q.erase) && !o_stat.done;
    endproperty
    a_frozen: assert property (p_frozen) else $error("suspended operation moved");

    property p_er_refused;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        q.st == ST_SUSP && i_req.start_erase && !i_req.resume
        |=> o_stat.refused && o_stat.suspended && !o_stat.busy;
    endproperty
    a_er_refused: assert property (p_er_refused) else $error("nested erase");

    property p_sect_refused;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        q.st == ST_SUSP && q.erase && i_req.start_prog && i_req.sector == q.sector
            && !i_req.start_erase && !i_req.resume |=> o_stat.refused && !o_stat.busy;
    endproperty
    a_sect_refused: assert property (p_sect_refused) else $error("same sector program");

    property p_resume;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        q.st == ST_SUSP && i_req.resume |=> q.st == ST_RUN && q.cnt == $past(q.cnt)
            ##1 o_stat.busy && !o_stat.suspended;
    endproperty
    a_resume: assert property (p_resume) else $error("resume did not continue");
endmodule : flash_susp_seq

// ### test/flash_host_model.sv
// host model: parameter reads and operation requests
module flash_host_model
    import flash_susp_pkg::*;
(
    // clock and status
    input wire logic i_clk_sys,
    input wire op_stat_t i_stat,
    // requests
    output logic o_param_rd,
    output logic [7:0] o_param_addr,
    output op_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ns;
    time t_res = 0;
    logic [SECT_W-1:0] er_sect = '0;
    initial begin
        o_param_rd = 1'b0;
        o_param_addr = 8'h00;
        o_req = '0;
    end
    task automatic read(input logic [7:0] addr);
        @(posedge i_clk_sys) #1;
        o_param_rd = 1'b1;
        o_param_addr = addr;
        @(posedge i_clk_sys) #1;
        o_param_rd = 1'b0;
        o_param_addr = ~addr;
    endtask : read
    // back-to-back reads of n consecutive offsets, strobe held high between them
    task automatic read_burst(input logic [7:0] addr, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk_sys) #1;
            o_param_rd = 1'b1;
            o_param_addr = addr + 8'(i);
        end
        @(posedge i_clk_sys) #1;
        o_param_rd = 1'b0;
        o_param_addr = ~addr;
    endtask : read_burst
    // kind 0 erase, 1 program, 2 suspend, 3 resume; bad lets a forbidden start through
    task automatic request(input int kind, input logic [SECT_W-1:0] sect, input bit bad);
        if (!bad && i_stat.suspended && kind == 0) return;
        if (!bad && i_stat.suspended && i_stat.susp_is_erase && kind == 1 && sect == er_sect)
            return;
        while (!bad && kind == 2 && t_res != 0 && $time - t_res < RES_GAP_NS) begin
            @(posedge i_clk_sys);
        end
        @(posedge i_clk_sys) #1;
        o_req.sector = sect;
        o_req.start_erase = (kind == 0);
        o_req.start_prog = (kind == 1);
        o_req.suspend = (kind == 2);
        o_req.resume = (kind == 3);
        @(posedge i_clk_sys) #1;
        o_req = '0;
        if (kind == 0 && !bad) er_sect = sect;
        if (kind == 3) t_res = $time;
    endtask : request
endmodule : flash_host_model

// ### test/flash_suspend_resume_params_tb_top.sv
// testbench: parameter word, suspend latency, freeze and refusals
module flash_suspend_resume_params_tb_top
    import flash_susp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic param_rd;
    logic [7:0] param_addr;
    logic param_valid;
    logic param_hit;
    logic [7:0] param_data;
    op_req_t req;
    op_stat_t stat;
    int miscompares = 0;
    int n_compared = 0;
    int busy_cnt = 0;

    always #25 clk = ~clk;
    // run cycles of the main operation, nested program and drain-free suspension excluded
    always @(posedge clk) begin
        if (stat.busy === 1'b1 && stat.suspended === 1'b0) begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    flash_susp_seq u_flash_susp_seq (.i_clk_sys(clk), .i_rst_n(rst_n), .i_param_rd(param_rd),
        .i_param_addr(param_addr), .o_param_valid(param_valid), .o_param_hit(param_hit),
        .o_param_data(param_data), .i_req(req), .o_stat(stat));
    flash_host_model u_flash_host_model (.i_clk_sys(clk), .i_stat(stat), .o_param_rd(param_rd),
        .o_param_addr(param_addr), .o_req(req));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    // waits until the flag probe is high, bounded
    task automatic wait_for(input int which, output int n);
        n = 0;
        while (n < 6000 && (which == 0 ? stat.suspended : stat.done) !== 1'b1) begin
            @(posedge clk) #1;
            n++;
        end
    endtask : wait_for

    task automatic t_params();
        logic [7:0] exp_b [4] = '{8'hEC, 8'h93, 8'h18, 8'h45};
        logic [7:0] outside [2] = '{8'h2B, 8'h30};
        logic [31:0] word;
        for (int i = 0; i < 4; i++) begin
            u_flash_host_model.read(WORD_BASE + 8'(i));
            check("valid", 32'(param_valid), 32'h1);
            check("hit", 32'(param_hit), 32'h1);
            check("byte", 32'(param_data), 32'(exp_b[i]));
            word[8*i+:8] = param_data;
        end
        u_flash_host_model.read_burst(WORD_BASE, 4);
        check("burst valid", 32'(param_valid), 32'h1);
        check("burst last byte", 32'(param_data), 32'(exp_b[3]));
        check("support bit", 32'(word[31]), 32'h0);
        check("reserved bit", 32'(word[8]), 32'h1);
        check("erase unit", 32'(word[30:29]), 32'h2);
        check("erase latency", (32'(word[28:24]) + 32'h1) * 32'd8000, 32'd48000);
        foreach (outside[k]) begin
            u_flash_host_model.read(outside[k]);
            check("outside hit", 32'(param_hit), 32'h0);
            check("outside byte", 32'(param_data), 32'h0);
        end
        $display("test params finished");
    endtask : t_params

    task automatic t_op(input int kind, input int dur);
        int n;
        int base;
        base = busy_cnt;
        u_flash_host_model.request(kind, 12'h005, 1'b0);
        repeat (100) @(posedge clk);
        u_flash_host_model.request(2, 12'h005, 1'b0);
        check("early flag clear", 32'(stat.early_suspend), 32'h0);
        wait_for(0, n);
        check("suspend latency ok", 32'(n <= SUSP_MAX_CYC), 32'h1);
        repeat (300) @(posedge clk);
        #1;
        check("still suspended", 32'(stat.suspended), 32'h1);
        check("frozen busy", 32'(stat.busy), 32'h0);
        u_flash_host_model.request(0, 12'h009, 1'b1);
        check("erase refused", 32'(stat.refused), 32'h1);
        if (kind == 0) begin
            u_flash_host_model.request(1, 12'h005, 1'b1);
            check("same sector refused", 32'(stat.refused), 32'h1);
            u_flash_host_model.request(1, 12'h00A, 1'b0);
            check("other sector taken", 32'(stat.refused), 32'h0);
            check("nested program busy", 32'(stat.busy), 32'h1);
            wait_for(1, n);
            @(posedge clk) #1;
            check("back in suspend", 32'(stat.suspended), 32'h1);
            check("suspended erase", 32'(stat.susp_is_erase), 32'h1);
            check("nest finished", 32'(stat.busy), 32'h0);
        end
        u_flash_host_model.request(3, 12'h005, 1'b0);
        wait_for(1, n);
        check("done seen", 32'(stat.done), 32'h1);
        check("run length", 32'(busy_cnt - base >= dur && busy_cnt - base <= dur + 60), 32'h1);
        $display("test op %0d finished", kind);
    endtask : t_op

    // suspend right after a resume: still honoured, but flagged as early
    task automatic t_early();
        int n;
        u_flash_host_model.request(0, 12'h007, 1'b0);
        u_flash_host_model.request(2, 12'h007, 1'b0);
        wait_for(0, n);
        u_flash_host_model.request(3, 12'h007, 1'b0);
        u_flash_host_model.request(2, 12'h007, 1'b1);
        check("early flag", 32'(stat.early_suspend), 32'h1);
        wait_for(0, n);
        check("early suspend honoured", 32'(stat.suspended), 32'h1);
        check("early suspend latency", 32'(n <= SUSP_MAX_CYC), 32'h1);
        u_flash_host_model.request(3, 12'h007, 1'b0);
        wait_for(1, n);
        check("early op done", 32'(stat.done), 32'h1);
        $display("test early finished");
    endtask : t_early

    initial begin
        #(60000 * 50);
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        t_params();
        t_op(0, int'(ERASE_CYC));
        t_op(1, int'(PROG_CYC));
        t_early();
        wrap_up();
    end
endmodule : flash_suspend_resume_params_tb_top
